// File: hdl/flash_params.svh
// Constants for the serial flash program and erase command decoder.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

`define OPC_PAGE        8'h02
`define OPC_PAGE_W      8'h12
`define OPC_QPAGE_A     8'h32
`define OPC_QPAGE_B     8'h38
`define OPC_QPAGE_W     8'h34
`define OPC_SMALL       8'h20
`define OPC_SMALL_W     8'h21
`define OPC_ALL_A       8'h60
`define OPC_ALL_B       8'hC7
`define OPC_LARGE       8'hD8
`define OPC_LARGE_W     8'hDC
`define OPC_STATUS_READ 8'h05
`define OPC_CLEAR       8'h30
`define OPC_LOCK        8'h04
`define OPC_UNLOCK      8'h06
`define OPC_REG_WRITE   8'h01
`define OPC_RESET_A     8'hF0
`define OPC_RESET_B     8'h0F

`define ST_BUSY_BIT     0
`define ST_LATCH_BIT    1
`define ST_EFAIL_BIT    5
`define ST_WFAIL_BIT    6

`define REG_STATUS      4'h0
`define REG_CTRL        4'h4
`define REG_NV          4'h8
`define CTRL_ADDR4_BIT  0
`define CTRL_PAGE512_BIT 1
`define CTRL_FAILW_BIT  2
`define CTRL_FAILE_BIT  3
`define CTRL_LEN_LSB    16
`define CTRL_MASK       32'hFFFF000F
`define CTRL_RESET      32'h01000000
`define NV_RESET        8'h00

`define PAGE_SMALL      10'h100
`define PAGE_LARGE      10'h200
`define ADDR_SHORT      10'h003
`define ADDR_LONG       10'h004
`define RESP_OKAY       2'b00
`define RESP_DECERR     2'b11
`endif

// File: hdl/flash_pkg.sv
// Types shared by the flash command decoder.
package flash_pkg;
	typedef enum logic [2:0] {PH_IDLE, PH_OPC, PH_ADDR, PH_DATA, PH_WAIT, PH_STATUS, PH_DROP} phase_type;
	typedef enum logic [3:0] {K_NONE, K_PAGE, K_QPAGE, K_WIPE, K_WIPE_ALL, K_REGW, K_CLR, K_LOCK, K_UNLOCK,
		K_SWRST} kind_type;
	typedef enum logic [1:0] {OP_NONE, OP_PAGE, OP_WIPE, OP_REG} op_type;
	typedef struct packed {
		logic        sck_q;
		logic        cs_q;
		phase_type   phase;
		kind_type    kind;
		op_type      op;
		logic        wide;
		logic [2:0]  bitcnt;
		logic [2:0]  fcnt;
		logic [7:0]  shreg;
		logic [7:0]  stat_sh;
		logic [9:0]  bytecnt;
		logic        so_r;
		logic        so_oe_n;
		logic        busy;
		logic        wfail;
		logic        efail;
		logic        latch;
		logic [15:0] timer;
		logic [31:0] ctrl;
		logic [7:0]  nv;
		logic [7:0]  nv_new;
		logic [7:0]  last_op;
		logic [7:0]  refused;
		logic        aw_h;
		logic        w_h;
		logic [3:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_type;
endpackage

// File: hdl/pin_sync.sv
// Two-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_type;

	sync_type s_r;
	sync_type s_nxt;

	always_comb begin
		s_nxt.meta = d;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r.meta <= RST_VAL;
			s_r.stable <= RST_VAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.stable;
endmodule
`default_nettype wire

// File: hdl/flash_cmd_decode.sv
// Serial flash program/erase command decoder with status flags and AXI4-Lite registers.
`timescale 1ns/1ns
`default_nettype none
`include "flash_params.svh"
module flash_cmd_decode (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        si,
	input  wire logic        hw_reset_n,
	output logic             so,
	output logic             so_oe_n,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [3:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [3:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);
	import flash_pkg::*;

	flash_pkg::state_type s_r;
	flash_pkg::state_type s_nxt;
	logic [3:0]  pins;
	logic        sck_s;
	logic        cs_s;
	logic        si_s;
	logic        hwr_s;
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_rise;
	logic        cs_fall;
	logic        fail;
	logic        byte_done;
	logic [7:0]  byte_in;
	logic [7:0]  live_stat;
	logic [9:0]  nb;
	logic [9:0]  page_max;
	logic [15:0] len_eff;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic [3:0]  wa;
	logic [31:0] wd;
	logic [3:0]  ws;

	////////////////////////////////////////////////////////////////////////////
	// Link pins are sampled by the system clock; SCK edges are found in the next-state logic.

	pin_sync #(
		.W       (4),
		.RST_VAL (4'hA)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({hw_reset_n, si, cs_n, sck}),
		.q   (pins)
	);

	assign sck_s = pins[0];
	assign cs_s  = pins[1];
	assign si_s  = pins[2];
	assign hwr_s = pins[3];

	assign awready = !s_r.aw_h && !s_r.bvalid;
	assign wready  = !s_r.w_h && !s_r.bvalid;
	assign arready = !s_r.rvalid;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		s_nxt = s_r;
		sck_rise = sck_s & ~s_r.sck_q;
		sck_fall = ~sck_s & s_r.sck_q;
		cs_rise = cs_s & ~s_r.cs_q;
		cs_fall = ~cs_s & s_r.cs_q;
		fail = s_r.wfail | s_r.efail;
		byte_in = {s_r.shreg[6:0], si_s};
		// Quad data carries four bits per clock, so a byte spans only two clocks.
		byte_done = (s_r.phase == PH_DATA && s_r.kind == K_QPAGE) ? (s_r.bitcnt == 3'd1) : (s_r.bitcnt == 3'd7);
		nb = s_r.bytecnt + 10'd1;
		page_max = s_r.ctrl[`CTRL_PAGE512_BIT] ? `PAGE_LARGE : `PAGE_SMALL;
		len_eff = (s_r.ctrl[31:16] == 16'h0000) ? 16'h0001 : s_r.ctrl[31:16];
		live_stat = 8'h00;
		live_stat[`ST_BUSY_BIT] = s_r.busy;
		live_stat[`ST_LATCH_BIT] = s_r.latch;
		live_stat[`ST_EFAIL_BIT] = s_r.efail;
		live_stat[`ST_WFAIL_BIT] = s_r.wfail;
		s_nxt.sck_q = sck_s;
		s_nxt.cs_q = cs_s;

		// Embedded operation timer; a failure leaves busy high until cleared.
		if (s_r.busy && !fail && s_r.op != OP_NONE) begin
			if (s_r.timer == 16'h0001) begin
				s_nxt.op = OP_NONE;
				if (s_r.op == OP_PAGE && s_r.ctrl[`CTRL_FAILW_BIT]) begin
					s_nxt.wfail = 1'b1;
				end else if (s_r.op == OP_WIPE && s_r.ctrl[`CTRL_FAILE_BIT]) begin
					s_nxt.efail = 1'b1;
				end else begin
					s_nxt.busy = 1'b0;
					s_nxt.latch = 1'b0;
				end
			end else begin
				s_nxt.timer = s_r.timer - 16'h0001;
			end
		end

		if (cs_fall) begin
			s_nxt.phase = PH_OPC;
			s_nxt.bitcnt = 3'd0;
			s_nxt.bytecnt = 10'd0;
		end else if (!cs_s && sck_rise && s_r.phase != PH_IDLE) begin
			s_nxt.shreg = byte_in;
			s_nxt.bitcnt = s_r.bitcnt + 3'd1;
			if (byte_done) begin
				s_nxt.bitcnt = 3'd0;
				case (s_r.phase)
				PH_OPC: begin
					s_nxt.last_op = byte_in;
					s_nxt.phase = PH_DROP;
					s_nxt.kind = K_NONE;
					s_nxt.wide = s_r.ctrl[`CTRL_ADDR4_BIT];
					s_nxt.bytecnt = 10'd0;
					if (fail && byte_in != `OPC_STATUS_READ && byte_in != `OPC_CLEAR && byte_in != `OPC_LOCK
						&& byte_in != `OPC_RESET_A && byte_in != `OPC_RESET_B) begin
						s_nxt.refused = s_r.refused + 8'h01;
					end else if (s_r.busy && !fail && byte_in != `OPC_STATUS_READ
						&& byte_in != `OPC_RESET_A && byte_in != `OPC_RESET_B) begin
						s_nxt.refused = s_r.refused + 8'h01;
					end else begin
						case (byte_in)
						`OPC_STATUS_READ: begin
							s_nxt.phase = PH_STATUS;
							s_nxt.fcnt = 3'd0;
						end
						`OPC_CLEAR: begin
							s_nxt.kind = K_CLR;
							s_nxt.phase = PH_WAIT;
						end
						`OPC_LOCK: begin
							s_nxt.kind = K_LOCK;
							s_nxt.phase = PH_WAIT;
						end
						`OPC_UNLOCK: begin
							s_nxt.kind = K_UNLOCK;
							s_nxt.phase = PH_WAIT;
						end
						`OPC_RESET_A, `OPC_RESET_B: begin
							s_nxt.kind = K_SWRST;
							s_nxt.phase = PH_WAIT;
						end
						`OPC_PAGE, `OPC_PAGE_W: begin
							s_nxt.kind = K_PAGE;
							s_nxt.wide = s_r.ctrl[`CTRL_ADDR4_BIT] | (byte_in == `OPC_PAGE_W);
							s_nxt.phase = PH_ADDR;
						end
						`OPC_QPAGE_A, `OPC_QPAGE_B, `OPC_QPAGE_W: begin
							s_nxt.kind = K_QPAGE;
							s_nxt.wide = s_r.ctrl[`CTRL_ADDR4_BIT] | (byte_in == `OPC_QPAGE_W);
							s_nxt.phase = PH_ADDR;
						end
						`OPC_SMALL, `OPC_SMALL_W, `OPC_LARGE, `OPC_LARGE_W: begin
							s_nxt.kind = K_WIPE;
							s_nxt.wide = s_r.ctrl[`CTRL_ADDR4_BIT] | (byte_in == `OPC_SMALL_W)
								| (byte_in == `OPC_LARGE_W);
							s_nxt.phase = PH_ADDR;
						end
						`OPC_ALL_A, `OPC_ALL_B: begin
							s_nxt.kind = K_WIPE_ALL;
							s_nxt.phase = PH_WAIT;
						end
						`OPC_REG_WRITE: begin
							s_nxt.kind = K_REGW;
							s_nxt.phase = PH_DATA;
						end
						default: begin
							s_nxt.phase = PH_DROP;
						end
						endcase
					end
				end
				PH_ADDR: begin
					s_nxt.bytecnt = nb;
					if (nb == (s_r.wide ? `ADDR_LONG : `ADDR_SHORT)) begin
						s_nxt.bytecnt = 10'd0;
						s_nxt.phase = (s_r.kind == K_WIPE) ? PH_WAIT : PH_DATA;
					end
				end
				PH_DATA: begin
					if (s_r.bytecnt != 10'h3FF) begin
						s_nxt.bytecnt = nb;
					end
					if (s_r.kind == K_REGW && s_r.bytecnt == 10'd0) begin
						s_nxt.nv_new = byte_in;
					end
				end
				// Further clocks after a complete wait-type command void it.
				PH_WAIT: begin
					s_nxt.phase = PH_DROP;
				end
				default: begin
				end
				endcase
			end
		end

		// Status byte goes out MSB first on falling SCK, refreshed every byte.
		if (!cs_s && sck_fall && s_r.phase == PH_STATUS) begin
			s_nxt.so_oe_n = 1'b0;
			s_nxt.fcnt = s_r.fcnt + 3'd1;
			if (s_r.fcnt == 3'd0) begin
				s_nxt.so_r = live_stat[7];
				s_nxt.stat_sh = {live_stat[6:0], 1'b0};
			end else begin
				s_nxt.so_r = s_r.stat_sh[7];
				s_nxt.stat_sh = {s_r.stat_sh[6:0], 1'b0};
			end
		end

		// Commands act only when chip select rises on a byte boundary.
		if (cs_rise) begin
			s_nxt.phase = PH_IDLE;
			s_nxt.so_oe_n = 1'b1;
			if (s_r.bitcnt == 3'd0) begin
				case (s_r.phase)
				PH_WAIT: begin
					case (s_r.kind)
					K_CLR: begin
						s_nxt.busy = 1'b0;
						s_nxt.wfail = 1'b0;
						s_nxt.efail = 1'b0;
						s_nxt.op = OP_NONE;
					end
					K_LOCK: begin
						s_nxt.latch = 1'b0;
					end
					K_UNLOCK: begin
						s_nxt.latch = 1'b1;
					end
					K_SWRST: begin
						s_nxt.busy = 1'b0;
						s_nxt.wfail = 1'b0;
						s_nxt.efail = 1'b0;
						s_nxt.latch = 1'b0;
						s_nxt.op = OP_NONE;
					end
					K_WIPE, K_WIPE_ALL: begin
						if (s_r.latch) begin
							s_nxt.busy = 1'b1;
							s_nxt.op = OP_WIPE;
							s_nxt.timer = len_eff;
						end
					end
					default: begin
					end
					endcase
				end
				PH_DATA: begin
					if (s_r.latch && s_r.bytecnt != 10'd0) begin
						if (s_r.kind == K_REGW) begin
							if (s_r.nv_new != s_r.nv) begin
								s_nxt.nv = s_r.nv_new;
								s_nxt.busy = 1'b1;
								s_nxt.op = OP_REG;
								s_nxt.timer = len_eff;
							end else begin
								s_nxt.latch = 1'b0;
							end
						end else if (s_r.bytecnt <= page_max) begin
							s_nxt.busy = 1'b1;
							s_nxt.op = OP_PAGE;
							s_nxt.timer = len_eff;
						end
					end
				end
				default: begin
				end
				endcase
			end
		end

		// A held hardware reset pin returns the device to standby.
		if (!hwr_s) begin
			s_nxt.phase = PH_IDLE;
			s_nxt.busy = 1'b0;
			s_nxt.wfail = 1'b0;
			s_nxt.efail = 1'b0;
			s_nxt.latch = 1'b0;
			s_nxt.op = OP_NONE;
			s_nxt.so_oe_n = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////
		// AXI4-Lite slave: address and data are taken in either order.

		aw_take = awvalid && awready;
		w_take = wvalid && wready;
		ar_take = arvalid && arready;
		wa = aw_take ? awaddr : s_r.awaddr;
		wd = w_take ? wdata : s_r.wdata;
		ws = w_take ? wstrb : s_r.wstrb;
		if (aw_take) begin
			s_nxt.aw_h = 1'b1;
			s_nxt.awaddr = awaddr;
		end
		if (w_take) begin
			s_nxt.w_h = 1'b1;
			s_nxt.wdata = wdata;
			s_nxt.wstrb = wstrb;
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if ((s_r.aw_h || aw_take) && (s_r.w_h || w_take)) begin
			s_nxt.aw_h = 1'b0;
			s_nxt.w_h = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `RESP_OKAY;
			case (wa)
			`REG_CTRL: begin
				for (int i = 0; i < 4; i++) begin
					if (ws[i]) begin
						s_nxt.ctrl[8*i +: 8] = wd[8*i +: 8];
					end
				end
				// Unused bits are cleared after the byte merge so they always read back as zero.
				s_nxt.ctrl = s_nxt.ctrl & `CTRL_MASK;
			end
			`REG_STATUS, `REG_NV: begin
			end
			default: begin
				s_nxt.bresp = `RESP_DECERR;
			end
			endcase
		end

		if (ar_take) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `RESP_OKAY;
			case (araddr)
			`REG_STATUS: s_nxt.rdata = {8'h00, s_r.refused, s_r.last_op, live_stat};
			`REG_CTRL: s_nxt.rdata = s_r.ctrl;
			`REG_NV: s_nxt.rdata = {24'h000000, s_r.nv};
			default: begin
				s_nxt.rdata = 32'h00000000;
				s_nxt.rresp = `RESP_DECERR;
			end
			endcase
		end else if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.cs_q <= 1'b1;
			s_r.so_oe_n <= 1'b1;
			s_r.ctrl <= `CTRL_RESET;
			s_r.nv <= `NV_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign so      = s_r.so_r;
	assign so_oe_n = s_r.so_oe_n;
	assign bvalid  = s_r.bvalid;
	assign bresp   = s_r.bresp;
	assign rvalid  = s_r.rvalid;
	assign rdata   = s_r.rdata;
	assign rresp   = s_r.rresp;
endmodule
`default_nettype wire

// File: testbench/flash_checker_assertions.sv
// Concurrent checks on the decoder's register bus and serial output enable.
`timescale 1ns/1ns
`default_nettype none
`include "flash_params.svh"
module flash_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        cs_n,
	input wire logic        so_oe_n,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [3:0]  araddr,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// The read data belongs to the address taken at the most recent read handshake.
	logic [3:0] rd_addr_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rd_addr_r <= 4'h0;
		else if (arvalid && arready)
			rd_addr_r <= araddr;
	end
	wire logic st_rd = rvalid && rd_addr_r == `REG_STATUS;
	wire logic bad_rd = rvalid && !(rd_addr_r inside {`REG_STATUS, `REG_CTRL, `REG_NV});
	property p_fail_busy;
		st_rd && (rdata[`ST_WFAIL_BIT] || rdata[`ST_EFAIL_BIT]) |-> rdata[`ST_BUSY_BIT];
	endproperty
	a_fail_busy: assert property (p_fail_busy) else $error("busy low with a failure flag set");
	property p_status_top;
		st_rd |-> rdata[31:24] == 8'h00;
	endproperty
	a_status_top: assert property (p_status_top) else $error("status top byte not zero");
	// Sync and register delay let the enable trail chip select by three cycles.
	property p_so_idle;
		cs_n [*6] |-> so_oe_n;
	endproperty
	a_so_idle: assert property (p_so_idle) else $error("serial output driven outside a frame");
	property p_r_answer;
		arvalid && arready |=> rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_unmapped;
		bad_rd |-> rresp == `RESP_DECERR && rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_b_answer;
		awvalid && awready && wvalid && wready |=> bvalid && !awready && !wready;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write answer late");
	property p_b_hold;
		bvalid && !bready |=> bvalid && !wready;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	c_fail: cover property (st_rd && rdata[`ST_WFAIL_BIT]);
	c_efail: cover property (st_rd && rdata[`ST_EFAIL_BIT]);
	c_unmapped: cover property (bad_rd);
endmodule
bind flash_cmd_decode flash_checker u_flash_checker (.clk, .rst, .cs_n, .so_oe_n, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
`default_nettype wire

// File: testbench/spi_host.sv
// Behavioural serial host that frames commands toward the decoder.
`timescale 1ns/1ns
`default_nettype none
module spi_host (
	input  wire logic clk,
	input  wire logic so,
	input  wire logic so_oe_n,
	output logic      sck,
	output logic      cs_n,
	output logic      si
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// Four clk per half period give a 32 ns serial clock, well under the quad write ceiling.
	task automatic xfer(input logic [63:0] d, input int n, output logic [7:0] rx);
		rx = 8'h00;
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			si <= d[63 - i];
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			// Sampled mid-cycle after the rise, while the output is certain to be settled.
			@(negedge clk);
			rx = {rx[6:0], so_oe_n ? ~rx[0] : so};
			repeat (4) @(posedge clk);
			sck <= 1'b0;
		end
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// File: testbench/serial_flash_command_decode_test.sv
// Self-checking bench for the flash program and erase command decoder.
`timescale 1ns/1ns
`default_nettype none
`include "flash_params.svh"
module serial_flash_command_decode_test;
	logic        clk = 1'b0, rst = 1'b1, hw_reset_n = 1'b1, sck, cs_n, si, so, so_oe_n;
	logic        awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
	logic        arvalid = 1'b0, arready, rvalid, rready = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
	logic [31:0] wdata = 32'h0, rdata, w;
	logic [1:0]  bresp, rresp, r;
	logic [7:0]  rx;
	logic [7:0]  codes [11] = '{`OPC_PAGE, `OPC_PAGE_W, `OPC_QPAGE_A, `OPC_QPAGE_B, `OPC_QPAGE_W,
		`OPC_SMALL, `OPC_SMALL_W, `OPC_LARGE, `OPC_LARGE_W, `OPC_ALL_A, `OPC_ALL_B};
	int          bits [11] = '{40, 48, 34, 34, 42, 32, 40, 32, 40, 8, 8};
	int          n_errors = 0, n_tests = 0, cyc = 0;
	always #2 clk = ~clk;
	flash_cmd_decode u_flash_cmd_decode (.clk, .rst, .sck, .cs_n, .si, .hw_reset_n, .so, .so_oe_n,
		.awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	spi_host u_spi_host (.clk, .so, .so_oe_n, .sck, .cs_n, .si);
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		n_tests++;
		if ((got & msk) !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got & msk, exp);
		end
	endtask
	// Readies are looked at mid-cycle, so the value seen is the one the next edge samples.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, hb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			hb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!hb);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a);
		logic ta, hr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ta = arvalid && arready;
			hr = rvalid;
			w = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end while (!hr);
		rready <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] c, input int n);
		u_spi_host.xfer({c, 56'h0}, n, rx);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		axi_rd(`REG_CTRL);
		chk(w, `CTRL_RESET, 32'hFFFFFFFF);
		axi_rd(`REG_NV);
		chk(w, {24'h0, `NV_RESET}, 32'hFFFFFFFF);
		axi_rd(4'hC);
		chk({r, w[29:0]}, {`RESP_DECERR, 30'h0}, 32'hFFFFFFFF);
		axi_wr(`REG_CTRL, 32'h010000F0);
		chk({30'h0, r}, {30'h0, `RESP_OKAY}, 32'h00000003);
		axi_rd(`REG_CTRL);
		chk(w, `CTRL_RESET, 32'hFFFFFFFF);
		axi_wr(4'hC, 32'h00000000);
		chk({30'h0, r}, {30'h0, `RESP_DECERR}, 32'h00000003);
	endtask
	task automatic t_fail();
		axi_wr(`REG_CTRL, 32'h01000004);
		cmd(`OPC_UNLOCK, 8);
		cmd(`OPC_PAGE, 40);
		repeat (300) @(posedge clk);
		cmd(`OPC_UNLOCK, 8);
		axi_rd(`REG_STATUS);
		chk(w, 32'h00010641, 32'hFFFFFFE1);
		u_spi_host.xfer({`OPC_STATUS_READ, 56'h0}, 16, rx);
		chk({24'h0, rx}, 32'h41, 32'hE1);
		cmd(`OPC_CLEAR, 8);
		axi_rd(`REG_STATUS);
		chk(w, 32'h0, 32'hE1);
		cmd(`OPC_LOCK, 8);
		axi_rd(`REG_STATUS);
		chk(w, 32'h0, 32'hFF);
		axi_wr(`REG_CTRL, `CTRL_RESET);
	endtask
	task automatic t_reset();
		for (int k = 0; k < 3; k++) begin
			axi_wr(`REG_CTRL, 32'h01000008);
			cmd(`OPC_UNLOCK, 8);
			cmd(`OPC_SMALL, 32);
			repeat (300) @(posedge clk);
			axi_rd(`REG_STATUS);
			chk(w, 32'h21, 32'hE1);
			if (k < 2) begin
				cmd(k == 0 ? `OPC_RESET_A : `OPC_RESET_B, 8);
			end else begin
				hw_reset_n <= 1'b0;
				repeat (5) @(posedge clk);
				hw_reset_n <= 1'b1;
				repeat (4) @(posedge clk);
			end
			axi_rd(`REG_STATUS);
			chk(w, 32'h0, 32'hFF);
		end
		axi_wr(`REG_CTRL, `CTRL_RESET);
	endtask
	task automatic t_refuse();
		cmd(`OPC_LARGE, 32);
		axi_rd(`REG_STATUS);
		chk(w, {16'h0, `OPC_LARGE, 8'h00}, 32'hFFFF);
		cmd(`OPC_UNLOCK, 8);
		cmd(`OPC_PAGE, 32);
		axi_rd(`REG_STATUS);
		chk(w, 32'h0, 32'h01);
		u_spi_host.xfer({`OPC_REG_WRITE, 8'hA5, 48'h0}, 16, rx);
		axi_rd(`REG_STATUS);
		chk(w, 32'h03, 32'hFF);
		repeat (300) @(posedge clk);
		axi_rd(`REG_NV);
		chk(w, 32'hA5, 32'hFFFFFFFF);
	endtask
	task automatic t_codes();
		for (int i = 0; i < 11; i++) begin
			cmd(`OPC_UNLOCK, 8);
			cmd(codes[i], bits[i]);
			axi_rd(`REG_STATUS);
			chk(w, {16'h0, codes[i], 8'h03}, 32'hFFFF);
			u_spi_host.xfer({`OPC_STATUS_READ, 56'h0}, 16, rx);
			chk({24'h0, rx}, 32'h03, 32'hFF);
			repeat (300) @(posedge clk);
			axi_rd(`REG_STATUS);
			chk(w, 32'h0, 32'hFF);
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_regs();
		t_fail();
		t_reset();
		t_refuse();
		t_codes();
		wrap_up();
	end
endmodule
`default_nettype wire
